// File: hw/five_channel_pulse_modulator.sv
// five channel pulse modulator with shared prescaler and counter
//
// What this block does
// (RULE1) five channels share one 8-bit prescaler
// (RULE2) one prescaler and counter for all channels
// (RULE3) counter runs 0 to 254 then wraps
// (RULE4) step lasts 2*(prescale+1) clock periods
// (RULE5) compare above counter drives output high
// (RULE6) compare at or below counter drives low
// (RULE7) 00h holds low, ffh holds high
// (RULE8) new compare value acts at once
// (RULE9) each channel has its own enable
// (RULE10) channel 4 pin needs extra output enable
// (RULE11) reset clears everything, outputs low
`timescale 1ns/1ps
`default_nettype none
`include "pulse_mod_cfg.svh"

module five_channel_pulse_modulator
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // settings
  input wire pulse_mod_pkg::byte_t i_prescale_value,
  input wire pulse_mod_pkg::byte_t i_pulse_compare_0,
  input wire pulse_mod_pkg::byte_t i_pulse_compare_1,
  input wire pulse_mod_pkg::byte_t i_pulse_compare_2,
  input wire pulse_mod_pkg::byte_t i_pulse_compare_3,
  input wire pulse_mod_pkg::byte_t i_pulse_compare_4,
  input wire pulse_mod_pkg::chan_bits_t i_channel_enable,
  input wire logic i_channel4_pin_output_enable,
  // outputs
  output var pulse_mod_pkg::chan_bits_t o_pulse,
  output var pulse_mod_pkg::byte_t o_count
);
  import pulse_mod_pkg::*;

  //----------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // async assert, two-flop release so every register leaves reset together
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  //----------------------------------------------------------------
  // shared prescaler and counter
  //----------------------------------------------------------------
  // prescale counter is 9 bits: 2*(255+1)-1 = 511 fits
  logic [8:0] pre_cnt;
  logic [8:0] step_last;
  logic step_done;
  byte_t count;
  byte_t cmp [`PM_CHANNELS];

  // settings are same-clock software values, no synchroniser needed
  assign step_last = 9'((`PM_STEP_HALVES * ({1'b0, i_prescale_value}
                     + 9'h001)) - 1); // RULE4
  assign step_done = (pre_cnt >= step_last);

  // prescaler; the >= compare recovers at once if prescale shrinks
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt <= 9'h000; // RULE11
    else if (step_done)
      pre_cnt <= 9'h000; // RULE1
    else
      pre_cnt <= pre_cnt + 9'h001;
  end

  // one counter for all channels keeps them phase aligned
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= `PM_RESET_BYTE; // RULE11
    else if (step_done)
    begin
      if (count >= `PM_COUNT_LAST)
        count <= 8'h00; // RULE3
      else
        count <= count + 8'h01; // RULE2
    end
  end

  //----------------------------------------------------------------
  // channel compare
  //----------------------------------------------------------------
  assign cmp[0] = i_pulse_compare_0;
  assign cmp[1] = i_pulse_compare_1;
  assign cmp[2] = i_pulse_compare_2;
  assign cmp[3] = i_pulse_compare_3;
  assign cmp[4] = i_pulse_compare_4;

  function automatic logic level_of(input byte_t c, input byte_t n);
    // counter never reaches ffh, so ffh always compares high
    level_of = (c > n); // RULE5 RULE6 RULE7
  endfunction : level_of

  chan_bits_t next_pulse;

  // compare reads live register, so a new value acts next cycle
  always_comb
  begin
    for (int i = 0; i < `PM_CHANNELS; i++)
      next_pulse[i] = i_channel_enable[i] &
        level_of(cmp[i], count); // RULE9 RULE8
    next_pulse[4] = next_pulse[4] & i_channel4_pin_output_enable; // RULE10
  end

  // outputs registered; one cycle latency behind the counter
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pulse <= 5'h00; // RULE11
      o_count <= 8'h00;
    end
    else
    begin
      o_pulse <= next_pulse;
      o_count <= count;
    end
  end

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  // helper: a step timer of its own, so the length check does not
  // just re-read the prescaler that it guards
  logic [8:0] gap;
  logic gap_ok;
  byte_t seen_pre;

  // gap_ok drops when the prescale moves, since that step is then odd
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap <= 9'h000;
      gap_ok <= 1'b0;
      seen_pre <= 8'h00;
    end
    else
    begin
      seen_pre <= i_prescale_value;
      if (step_done)
      begin
        gap <= 9'h000;
        gap_ok <= 1'b1;
      end
      else
      begin
        gap <= gap + 9'h001;
        gap_ok <= gap_ok & (i_prescale_value == seen_pre);
      end
    end
  end

  chk_count_range: assert property ( // RULE3
    @(posedge i_clk) disable iff (!rst_n)
    count <= `PM_COUNT_LAST)
    else $error("counter passed 254");
  chk_count_wrap: assert property ( // RULE3
    @(posedge i_clk) disable iff (!rst_n)
    (step_done && count == `PM_COUNT_LAST) |=> count == 8'h00)
    else $error("counter did not wrap");
  chk_step_hold: assert property ( // RULE4
    @(posedge i_clk) disable iff (!rst_n)
    !step_done |=> $stable(count))
    else $error("counter moved early");
  chk_step_len: assert property ( // RULE4
    @(posedge i_clk) disable iff (!rst_n)
    (step_done && i_prescale_value == 8'h00) |=>
    (!step_done ##1 (step_done || i_prescale_value != 8'h00)))
    else $error("prescale zero step not two cycles");
  chk_step_gap: assert property ( // RULE4
    @(posedge i_clk) disable iff (!rst_n)
    (gap_ok && i_prescale_value == seen_pre) |->
    (step_done == (gap == {i_prescale_value, 1'b1})))
    else $error("counter step length wrong");
  chk_out_high: assert property ( // RULE5
    @(posedge i_clk) disable iff (!rst_n)
    (i_channel_enable[0] && i_pulse_compare_0 > count) |=> o_pulse[0])
    else $error("channel 0 not high");
  chk_out_low: assert property ( // RULE6
    @(posedge i_clk) disable iff (!rst_n)
    (i_pulse_compare_1 <= count) |=> !o_pulse[1])
    else $error("channel 1 not low");
  chk_ffh_high: assert property ( // RULE7
    @(posedge i_clk) disable iff (!rst_n)
    (i_channel_enable[2] && i_pulse_compare_2 == 8'hff) |=> o_pulse[2])
    else $error("ffh not held high");
  chk_zero_low: assert property ( // RULE7
    @(posedge i_clk) disable iff (!rst_n)
    (i_pulse_compare_0 == 8'h00) |=> !o_pulse[0])
    else $error("00h not held low");
  chk_new_compare: assert property ( // RULE8
    @(posedge i_clk) disable iff (!rst_n)
    ($changed(i_pulse_compare_3) && i_channel_enable[3]) |=>
    (o_pulse[3] == ($past(i_pulse_compare_3) > $past(count))))
    else $error("new compare value not applied at once");
  chk_disable_low: assert property ( // RULE9
    @(posedge i_clk) disable iff (!rst_n)
    !i_channel_enable[3] |=> !o_pulse[3])
    else $error("disabled channel driven");
  chk_pin_gate: assert property ( // RULE10
    @(posedge i_clk) disable iff (!rst_n)
    !i_channel4_pin_output_enable |=> !o_pulse[4])
    else $error("channel 4 pin not gated");
  chk_pin_pass: assert property ( // RULE10
    @(posedge i_clk) disable iff (!rst_n)
    (i_channel4_pin_output_enable && i_channel_enable[4] &&
    i_pulse_compare_4 > count) |=> o_pulse[4])
    else $error("channel 4 pin not passed");
  chk_count_sync: assert property ( // RULE2
    @(posedge i_clk) disable iff (!rst_n)
    1'b1 |=> o_count == $past(count))
    else $error("count output lags wrong");
  chk_reset_quiet: assert property ( // RULE11
    @(posedge i_clk)
    !rst_n |-> (o_pulse == 5'h00 && o_count == 8'h00))
    else $error("outputs not cleared in reset");
endmodule : five_channel_pulse_modulator
`default_nettype wire

// File: hw/pulse_mod_cfg.svh
// constants for the five channel pulse modulator
`ifndef PULSE_MOD_CFG_SVH
`define PULSE_MOD_CFG_SVH
`define PM_CHANNELS 5
`define PM_COUNT_LAST 8'hfe
`define PM_STEP_HALVES 2
`define PM_RESET_BYTE 8'h00
`endif

// File: hw/pulse_mod_pkg.sv
// types shared by the five channel pulse modulator
package pulse_mod_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] chan_bits_t;
endpackage : pulse_mod_pkg

// File: testbench/motor_buffer.sv
// load buffer model fed by the channel 4 pin
`timescale 1ns/1ps
`default_nettype none
module motor_buffer
(
  // clock and drive
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_drive,
  // load state
  output var int o_on_cycles
);
  // count driven-high cycles; the weak pull-up is not a drive
  always @(posedge i_clk)
    o_on_cycles <= i_clear ? 0 : o_on_cycles + int'(i_drive === 1'b1);
endmodule : motor_buffer
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the five channel pulse modulator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pulse_mod_pkg::*;
  logic i_clk = 0, i_arst_n = 0, oe = 0, clr = 1;
  byte_t pre = 0, o_count, exp_c = 0;
  byte_t cmp [5] = '{default: 8'h00};
  chan_bits_t en = 0, o_pulse, exp_p = 0;
  int failures = 0, checks = 0, cyc = 0, edges = 0, mc = 0, mp = 0, on_cyc;
  int hi4 = 0;
  always #20 i_clk = ~i_clk;
  five_channel_pulse_modulator dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_prescale_value(pre), .i_pulse_compare_0(cmp[0]),
    .i_pulse_compare_1(cmp[1]), .i_pulse_compare_2(cmp[2]),
    .i_pulse_compare_3(cmp[3]), .i_pulse_compare_4(cmp[4]),
    .i_channel_enable(en), .i_channel4_pin_output_enable(oe),
    .o_pulse(o_pulse), .o_count(o_count));
  motor_buffer load (.i_clk(i_clk), .i_clear(clr), .i_drive(o_pulse[4]),
    .o_on_cycles(on_cyc));
  // reference: outputs from the count held before this edge, then step
  always @(posedge i_clk)
  begin
    // high cycles the load should have seen, from the level before this edge
    hi4 = clr ? 0 : hi4 + exp_p[4];
    edges = i_arst_n ? edges + 1 : 0;
    cyc++;
    if (edges < 3)
    begin
      exp_p = 0;
      exp_c = 0;
      mc = 0;
      mp = 0;
    end
    else
    begin
      for (int n = 0; n < 5; n++)
        exp_p[n] = en[n] && cmp[n] > mc && (n < 4 || oe);
      exp_c = 8'(mc);
      mp = (mp == 2 * (pre + 1) - 1) ? 0 : mp + 1;
      if (mp == 0)
        mc = (mc == 254) ? 0 : mc + 1;
    end
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // second and later resets land mid-run, on a falling edge
  task run(input byte_t p, input int n, input logic pin_oe);
    @(negedge i_clk) i_arst_n = 0;
    clr = 1;
    pre = p;
    oe = pin_oe;
    repeat (12) @(negedge i_clk);
    i_arst_n = 1;
    clr = 0;
    for (int c = 0; c < n; c++)
    begin
      @(negedge i_clk);
      check(8'(o_pulse), 8'(exp_p));
      check(o_count, exp_c);
      if (c % 37 == 0)
      begin
        en = 5'($urandom);
        for (int k = 0; k < 5; k++)
          cmp[k] = $urandom % 3 ? 8'($urandom) : {8{1'($urandom)}};
      end
    end
    $display("test done prescale=%0d", p);
  endtask : run
  task close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    void'($urandom(83321));
    run(8'h00, 1200, 1'b1);
    run(8'h03, 2200, 1'b1);
    check(on_cyc, hi4);
    run(8'hff, 1300, 1'b0);
    check(8'(on_cyc != 0), 8'h00);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
